// ### rtl/acd_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types of the AC load diagnostic sequencer
// ---------------------------------------------------------------------------
package acd_pkg;

  // -------------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_CFG = 8'h00; // Channel mode configuration
  localparam logic [7:0] ADDR_STATE_RPT = 8'h0c; // Channel state report
  localparam logic [7:0] ADDR_DIAG_EN = 8'h15; // AC diagnostic enables
  localparam logic [7:0] ADDR_LOOP_CTRL = 8'h16; // Loopback control
  localparam logic [7:0] ADDR_IMP_CH1 = 8'h17; // Impedance code, channel 1
  localparam logic [7:0] ADDR_IMP_CH2 = 8'h18; // Impedance code, channel 2
  localparam logic [7:0] ADDR_PHASE_HI = 8'h1b; // Phase, upper byte
  localparam logic [7:0] ADDR_PHASE_LO = 8'h1c; // Phase, lower byte
  localparam logic [7:0] ADDR_STIM_HI = 8'h1d; // Stimulus, upper byte
  localparam logic [7:0] ADDR_STIM_LO = 8'h1e; // Stimulus, lower byte

  // -------------------------------------------------------------------------
  // Field positions and reset values
  // -------------------------------------------------------------------------
  localparam int BIT_EN_CH1 = 3; // Channel 1 enable, also shared sense loop
  localparam int BIT_EN_CH2 = 2; // Channel 2 enable
  localparam int BIT_LOOPBACK = 7; // Phase reference loop enable
  localparam int BIT_PAIR_LO = 4; // Paralleled pair select, low bit
  localparam int BIT_PAIR_HI = 5; // Paralleled pair select, high bit
  localparam int RPT_DONE_LSB = 4; // Done flags start here in the report
  localparam logic [7:0] RST_MODE_CFG = 8'h00; // Mode configuration reset
  localparam logic [7:0] RST_DIAG_EN = 8'h00; // Enable register reset
  localparam logic [7:0] RST_LOOP_CTRL = 8'h00; // Loopback register reset
  localparam logic [7:0] RST_RESULT = 8'h00; // Result registers reset
  localparam logic [1:0] CH_FLOAT = 2'h0; // Report code: output floating
  localparam logic [1:0] CH_AC_DIAG = 2'h1; // Report code: AC diagnostic

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100; // System clock period
  localparam int RAMP_STEP_NS = 1000; // Least time per ramp step
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_STEP_LAST = 8'(RAMP_STEP_CYC - 1); // Last count of a step
  localparam logic [3:0] RAMP_TOP = 4'hf; // Full stimulus level
  localparam logic [3:0] RAMP_ZERO = 4'h0; // Silent stimulus level

  // -------------------------------------------------------------------------
  // Serial control port
  // -------------------------------------------------------------------------
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2a; // Arbitrary device address
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8; // Bits in one byte

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RAMP_UP = 2'b01,
    SEQ_MEASURE = 2'b10,
    SEQ_RAMP_DOWN = 2'b11
  } acd_seq_e;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK = 3'b010,
    I2C_PTR = 3'b011,
    I2C_WR = 3'b100,
    I2C_RD = 3'b101,
    I2C_RACK = 3'b110
  } acd_i2c_e;

  typedef struct packed {
    logic valid; // One-cycle pulse: sense result ready
    logic [7:0] impedance; // Impedance code
    logic [15:0] phase; // Phase value
    logic [15:0] stimulus; // Stimulus value
  } acd_meas_s;

  typedef struct packed {
    logic en; // One-cycle write strobe
    logic [7:0] addr; // Register offset
    logic [7:0] data; // Write data
  } acd_wr_s;

endpackage

// ### rtl/acd_i2c_slave.sv
`timescale 1ns/100ps
`default_nettype none
module acd_i2c_slave
  import acd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output acd_wr_s wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  // -------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // -------------------------------------------------------------------------
  logic [2:0] scl_q; // Stage 0 feeds stage 1 only
  logic [2:0] sda_q; // Stage 0 feeds stage 1 only
  acd_i2c_e state; // Protocol state
  acd_i2c_e after_ack; // State entered after an acknowledge
  logic [3:0] bit_cnt; // Bits taken in this byte
  logic [7:0] shreg; // Shift register
  logic [7:0] ptr; // Register pointer, auto increments

  // Two flops per pin, a third for edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else if (ce) begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  wire stop_cond = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign rd_addr = ptr;

  // -------------------------------------------------------------------------
  // Protocol engine
  // -------------------------------------------------------------------------
  // Data is taken on rising clock, driven after falling clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= I2C_IDLE;
      after_ack <= I2C_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr <= '0;
    end else if (ce) begin
      wr.en <= 1'b0;
      sda_out <= 1'b0;
      if (start_cond) begin
        // Start or repeated start
        state <= I2C_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        // Stop releases the line
        state <= I2C_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == I2C_RACK) begin
          // Master nack ends the read, ack asks for more
          state <= sda_q[1] ? I2C_IDLE : I2C_ACK;
          after_ack <= I2C_RD;
        end else if (state != I2C_IDLE && state != I2C_ACK) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (state != I2C_RD) begin
            shreg <= {shreg[6:0], sda_q[1]};
          end
        end
      end else if (scl_fall) begin
        case (state)
          I2C_ADDR: begin
            if (bit_cnt == I2C_BYTE_BITS) begin
              if (shreg[7:1] == I2C_DEV_ADDR) begin
                sda_oe <= 1'b1;
                state <= I2C_ACK;
                after_ack <= shreg[0] ? I2C_RD : I2C_PTR;
              end else begin
                state <= I2C_IDLE;
              end
            end
          end
          I2C_PTR: begin
            if (bit_cnt == I2C_BYTE_BITS) begin
              ptr <= shreg;
              sda_oe <= 1'b1;
              state <= I2C_ACK;
              after_ack <= I2C_WR;
            end
          end
          I2C_WR: begin
            if (bit_cnt == I2C_BYTE_BITS) begin
              wr <= '{en: 1'b1, addr: ptr, data: shreg};
              ptr <= ptr + 8'h01;
              sda_oe <= 1'b1;
              state <= I2C_ACK;
            end
          end
          I2C_ACK: begin
            bit_cnt <= 4'h0;
            state <= after_ack;
            if (after_ack == I2C_RD) begin
              // Load the byte at the pointer and drive its first bit
              shreg <= rd_data;
              ptr <= ptr + 8'h01;
              sda_oe <= ~rd_data[7];
            end else begin
              sda_oe <= 1'b0;
            end
          end
          I2C_RD: begin
            if (bit_cnt == I2C_BYTE_BITS) begin
              sda_oe <= 1'b0;
              state <= I2C_RACK;
            end else begin
              sda_oe <= ~shreg[3'(4'h7 - bit_cnt)];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule // acd_i2c_slave
`default_nettype wire

// ### rtl/acd_ac_load_diag_sequencer.sv
// Operation
// R1 - Run only while external stimulus is present (code checks it only at start; a run in progress continues without it)
// R2 - Host tests one channel at a time
// R3 - Host floats channels before magnitude test
// R4 - Host feeds full-scale 10-20 kHz tone
// R5 - Device ramps stimulus up and down itself
// R6 - Enable bits 3, 2 start channels 1, 2
// R7 - Impedance codes stored per channel
// R8 - Channel returns to floating, report shows it
// R9 - Host scales code by 2.371 mV
// R10 - Loopback bit 7 captures phase reference
// R11 - Host uses 19 kHz, shared channel 1 loop
// R12 - Phase reported as two bytes
// R13 - Host clears bit 3 after reading
// R14 - Pair bits select bridge or paralleled
// R15 - Stimulus value reported during load measurement
// R16 - Host measures load phase per channel
// R17 - Host computes phase from three values
// R18 - Gain 4 code scaling, host side
// R19 - Gain 1 code scaling, host side
// R20 - Results hold until next run
`timescale 1ns/100ps
`default_nettype none
module acd_ac_load_diag_sequencer
  import acd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic STIM_PRESENT,
  input wire acd_meas_s MEAS,
  output logic [3:0] STIM_GAIN,
  output logic MEAS_REQ,
  output logic [1:0] DIAG_CH,
  output logic LOOP_EN,
  output logic SENSE_LOOP_CH1,
  output logic PAIR_PARALLEL
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  acd_wr_s wr; // Register write strobe from the serial port
  logic [7:0] rd_addr; // Register read pointer
  logic [7:0] rd_data; // Register read data
  logic [7:0] mode_cfg; // Channel mode configuration
  logic [7:0] diag_en; // AC diagnostic enables
  logic [7:0] loop_ctrl; // Loopback control
  logic [7:0] imp [2]; // Impedance code per channel
  logic [15:0] phase; // Last phase result
  logic [15:0] stimulus; // Last load-mode stimulus result
  logic [1:0] ch_code [2]; // Reported state per channel
  logic [1:0] done; // Sticky run-complete flags
  logic [1:0] en_ch; // Effective channel enables
  logic [1:0] en_q; // Enables one cycle ago
  logic [1:0] pend; // Channel waiting for a run
  acd_seq_e state; // Sequencer state
  logic cur_ch; // Channel under test
  logic [7:0] step_cnt; // Cycles within a ramp step
  wire paralleled = mode_cfg[BIT_PAIR_HI] & mode_cfg[BIT_PAIR_LO];
  wire step_tick = CE && (step_cnt == RAMP_STEP_LAST);
  wire start = CE && (state == SEQ_IDLE) && (|pend) && STIM_PRESENT;
  wire next_ch = ~pend[0];
  wire capture = CE && (state == SEQ_MEASURE) && MEAS.valid;
  wire seq_done = step_tick && (state == SEQ_RAMP_DOWN) && (STIM_GAIN == RAMP_ZERO);

  // -------------------------------------------------------------------------
  // Serial control port
  // -------------------------------------------------------------------------
  acd_i2c_slave u_i2c (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_out(SDA_OUT),
    .sda_oe(SDA_OE),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // -------------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------------
  // Writable registers, decoded by offset
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_cfg <= RST_MODE_CFG;
      diag_en <= RST_DIAG_EN;
      loop_ctrl <= RST_LOOP_CTRL;
    end else if (CE && wr.en) begin
      if (wr.addr == ADDR_MODE_CFG) begin
        mode_cfg <= wr.data; // R14
      end else if (wr.addr == ADDR_DIAG_EN) begin
        diag_en <= wr.data; // R6
      end else if (wr.addr == ADDR_LOOP_CTRL) begin
        loop_ctrl <= wr.data; // R10
      end
    end
  end

  // Control bits driven to the analog path
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LOOP_EN <= 1'b0;
      SENSE_LOOP_CH1 <= 1'b0;
      PAIR_PARALLEL <= 1'b0;
    end else if (CE) begin
      LOOP_EN <= loop_ctrl[BIT_LOOPBACK]; // R10
      SENSE_LOOP_CH1 <= diag_en[BIT_EN_CH1]; // R11
      PAIR_PARALLEL <= paralleled; // R14
    end
  end

  // In paralleled mode only channel 1 may be tested
  assign en_ch[0] = diag_en[BIT_EN_CH1]; // R6
  assign en_ch[1] = diag_en[BIT_EN_CH2] & ~paralleled; // R6

  // -------------------------------------------------------------------------
  // Per-channel request, result and report state
  // -------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ch
    // A rising enable queues one run; dropping it cancels the request
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        en_q[g] <= 1'b0;
        pend[g] <= 1'b0;
      end else if (CE) begin
        en_q[g] <= en_ch[g];
        if (en_ch[g] && !en_q[g]) begin
          pend[g] <= 1'b1; // R6
        end else if (!en_ch[g] || (start && (next_ch == 1'(g)))) begin
          pend[g] <= 1'b0;
        end
      end
    end

    // Impedance code is written only by this channel's capture
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        imp[g] <= RST_RESULT;
      end else if (capture && (cur_ch == 1'(g))) begin
        imp[g] <= MEAS.impedance; // R7 R20
      end
    end

    // Reported state and sticky done flag
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        ch_code[g] <= CH_FLOAT;
        done[g] <= 1'b0;
      end else if (start && (next_ch == 1'(g))) begin
        ch_code[g] <= CH_AC_DIAG;
        done[g] <= 1'b0;
      end else if (seq_done && (cur_ch == 1'(g))) begin
        ch_code[g] <= CH_FLOAT; // R8
        done[g] <= 1'b1; // R8
      end
    end
  end

  // -------------------------------------------------------------------------
  // Diagnostic sequencer
  // -------------------------------------------------------------------------
  // Ramp up, take one sense result, ramp down, back to floating
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= SEQ_IDLE;
      cur_ch <= 1'b0;
      step_cnt <= 8'h00;
      STIM_GAIN <= RAMP_ZERO;
    end else if (CE) begin
      case (state)
        SEQ_IDLE: begin
          // Waits for both a request and an external tone
          if (start) begin
            state <= SEQ_RAMP_UP; // R1
            cur_ch <= next_ch;
            step_cnt <= 8'h00;
            STIM_GAIN <= RAMP_ZERO;
          end
        end
        SEQ_RAMP_UP: begin
          if (step_tick) begin
            step_cnt <= 8'h00;
            if (STIM_GAIN == RAMP_TOP) begin
              state <= SEQ_MEASURE;
            end else begin
              STIM_GAIN <= STIM_GAIN + 4'h1; // R5
            end
          end else begin
            step_cnt <= step_cnt + 8'h01;
          end
        end
        SEQ_MEASURE: begin
          // Holds full level until the sense path answers
          if (MEAS.valid) begin
            state <= SEQ_RAMP_DOWN;
            step_cnt <= 8'h00;
          end
        end
        SEQ_RAMP_DOWN: begin
          if (step_tick) begin
            step_cnt <= 8'h00;
            if (STIM_GAIN == RAMP_ZERO) begin
              state <= SEQ_IDLE;
            end else begin
              STIM_GAIN <= STIM_GAIN - 4'h1; // R5
            end
          end else begin
            step_cnt <= step_cnt + 8'h01;
          end
        end
        default: begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Measurement request and active channel outputs
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEAS_REQ <= 1'b0;
      DIAG_CH <= 2'b00;
    end else if (CE) begin
      if (start) begin
        DIAG_CH <= next_ch ? 2'b10 : 2'b01; // R6
      end else if (seq_done) begin
        DIAG_CH <= 2'b00; // R8
      end
      if (capture) begin
        MEAS_REQ <= 1'b0;
      end else if (state == SEQ_RAMP_UP && step_tick && STIM_GAIN == RAMP_TOP) begin
        MEAS_REQ <= 1'b1;
      end
    end
  end

  // Shared phase and stimulus results
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase <= {RST_RESULT, RST_RESULT};
      stimulus <= {RST_RESULT, RST_RESULT};
    end else if (capture) begin
      phase <= MEAS.phase; // R10 R12
      if (!loop_ctrl[BIT_LOOPBACK]) begin
        stimulus <= MEAS.stimulus; // R15
      end
    end
  end

  // -------------------------------------------------------------------------
  // Register read decode
  // -------------------------------------------------------------------------
  always_comb begin
    if (rd_addr == ADDR_MODE_CFG) begin
      rd_data = mode_cfg;
    end else if (rd_addr == ADDR_STATE_RPT) begin
      rd_data = {2'b00, done, ch_code[1], ch_code[0]}; // R8
    end else if (rd_addr == ADDR_DIAG_EN) begin
      rd_data = diag_en;
    end else if (rd_addr == ADDR_LOOP_CTRL) begin
      rd_data = loop_ctrl;
    end else if (rd_addr == ADDR_IMP_CH1) begin
      rd_data = imp[0]; // R7
    end else if (rd_addr == ADDR_IMP_CH2) begin
      rd_data = imp[1]; // R7
    end else if (rd_addr == ADDR_PHASE_HI) begin
      rd_data = phase[15:8]; // R12
    end else if (rd_addr == ADDR_PHASE_LO) begin
      rd_data = phase[7:0]; // R12
    end else if (rd_addr == ADDR_STIM_HI) begin
      rd_data = stimulus[15:8]; // R15
    end else if (rd_addr == ADDR_STIM_LO) begin
      rd_data = stimulus[7:0]; // R15
    end else begin
      rd_data = 8'h00;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  ramp_up_step_a: assert property ( // R5
    step_tick && state == SEQ_RAMP_UP && STIM_GAIN != RAMP_TOP
    |=> STIM_GAIN == $past(STIM_GAIN) + 4'h1) else $error("ramp up step wrong");
  ramp_full_meas_a: assert property ($rose(MEAS_REQ) |-> STIM_GAIN == RAMP_TOP) // R5
    else $error("measure before full ramp");
  stim_needed_a: assert property ($rose(|DIAG_CH) |-> $past(STIM_PRESENT)) // R1
    else $error("run started without stimulus");
  single_channel_a: assert property ($onehot0(DIAG_CH)) // R6
    else $error("two channels active");
  pair_ch2_blocked_a: assert property ($rose(DIAG_CH[1]) |-> !$past(paralleled)) // R6
    else $error("channel 2 run while paralleled");
  imp_capture_a: assert property ( // R7
    capture |=> imp[$past(cur_ch)] == $past(MEAS.impedance))
    else $error("impedance not stored");
  float_after_done_a: assert property ( // R8
    seq_done |=> DIAG_CH == 2'b00 ##0
    ch_code[$past(cur_ch)] == CH_FLOAT ##0 done[$past(cur_ch)])
    else $error("no return to float");
  phase_capture_a: assert property (capture |=> phase == $past(MEAS.phase)) // R12
    else $error("phase not stored");
  stim_loop_hold_a: assert property ( // R15
    capture && loop_ctrl[BIT_LOOPBACK] |=> $stable(stimulus))
    else $error("stimulus taken in loopback");
  results_hold_a: assert property ( // R20
    !capture |=> $stable(phase) && $stable(imp[0]) && $stable(imp[1]))
    else $error("results changed without run");
  loop_out_a: assert property ( // R10
    CE && wr.en && wr.addr == ADDR_LOOP_CTRL ##1 CE
    |=> LOOP_EN == $past(wr.data[BIT_LOOPBACK], 2)) else $error("loopback output wrong");

  run_ch1_c: cover property (start && !next_ch ##[1:400] seq_done);
  run_ch2_c: cover property (start && next_ch ##[1:400] seq_done);
  loop_capture_c: cover property (capture && loop_ctrl[BIT_LOOPBACK]);
  wait_stim_c: cover property ((state == SEQ_IDLE) && (|pend) && !STIM_PRESENT);

endmodule // acd_ac_load_diag_sequencer
`default_nettype wire

// ### bench/acd_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// Tone source and sense front end, answering measurement requests
// ---------------------------------------------------------------------------
module acd_src_model
  import acd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tone_on,
  input wire logic meas_req,
  input wire logic [7:0] dly,
  input wire logic [39:0] vals,
  output logic stim_present,
  output acd_meas_s meas
);
  logic [7:0] cnt; // Cycles spent waiting on the current request
  // Tone is only present while the bench plays it
  assign stim_present = tone_on;
  // Answer after dly cycles; data lines scramble when not valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      meas <= '0;
    end else begin
      meas.valid <= meas_req && !meas.valid && cnt == dly;
      cnt <= (meas_req && !meas.valid) ? cnt + 8'h01 : 8'h00;
      meas[39:0] <= (meas_req && cnt == dly) ? vals : ~meas[39:0];
    end
  end
endmodule // acd_src_model
`default_nettype wire

// ### bench/acd_ac_load_diag_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module acd_ac_load_diag_sequencer_tb
  import acd_pkg::*;
;
  logic SYS_CLK = 0, ARST_N = 0, scl = 1, sda_m = 1, tone = 1, ce = 1;
  logic SDA_OUT, SDA_OE, MEAS_REQ, LOOP_EN, SENSE_LOOP_CH1, PAIR_PARALLEL, stim;
  logic [3:0] STIM_GAIN, gmax = 4'h0;
  logic [1:0] DIAG_CH;
  logic [7:0] dly = 8'h00;
  logic [39:0] vals = 40'h5a_1234_abcd;
  acd_meas_s MEAS;
  int fails = 0, n_checks = 0, i;
  wire sda = sda_m & ~SDA_OE; // Open drain with pull-up
  always #50 SYS_CLK = ~SYS_CLK;
  // Gain seen while a measurement is awaited
  always @(posedge SYS_CLK) if (MEAS_REQ) gmax <= STIM_GAIN;
  acd_ac_load_diag_sequencer dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CE(ce),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .STIM_PRESENT(stim), .MEAS(MEAS), .STIM_GAIN(STIM_GAIN), .MEAS_REQ(MEAS_REQ),
    .DIAG_CH(DIAG_CH), .LOOP_EN(LOOP_EN), .SENSE_LOOP_CH1(SENSE_LOOP_CH1),
    .PAIR_PARALLEL(PAIR_PARALLEL));
  acd_src_model src (.clk(SYS_CLK), .arst_n(ARST_N), .tone_on(tone), .meas_req(MEAS_REQ),
    .dly(dly), .vals(vals), .stim_present(stim), .meas(MEAS));
  // ---------------------------------------------------------------------------
  // Checking and serial bus tasks
  // ---------------------------------------------------------------------------
  task tally_and_finish;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task hp;
    repeat (5) @(negedge SYS_CLK);
  endtask
  task bit_io(input logic b, output logic r);
    sda_m = b; hp; scl = 1; hp; r = sda; scl = 0; hp;
  endtask
  task start;
    sda_m = 1; hp; scl = 1; hp; sda_m = 0; hp; scl = 0; hp;
  endtask
  task stop;
    sda_m = 0; hp; scl = 1; hp; sda_m = 1; hp;
  endtask
  // One byte, then the ninth bit; device acknowledge checked when writing
  task xbyte(input logic [7:0] w, input logic wr, output logic [7:0] r);
    logic a;
    for (int k = 7; k >= 0; k--) bit_io(w[k], r[k]);
    bit_io(1'b1, a);
    if (wr) chk({7'h0, a}, 8'h00);
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start; xbyte({I2C_DEV_ADDR, 1'b0}, 1, r); xbyte(a, 1, r); xbyte(d, 1, r); stop;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    start; xbyte({I2C_DEV_ADDR, 1'b0}, 1, r); xbyte(a, 1, r);
    start; xbyte({I2C_DEV_ADDR, 1'b1}, 1, r); xbyte(8'hff, 0, r); stop;
    chk(r, e);
  endtask
  // Bounded wait for the channel under test
  task wait_ch(input logic [1:0] e);
    for (i = 0; i < 3000 && DIAG_CH !== e; i++) @(negedge SYS_CLK);
    if (DIAG_CH !== e) begin
      chk({6'h0, DIAG_CH}, {6'h0, e});
      tally_and_finish;
    end
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(negedge SYS_CLK);
    ARST_N = 1;
    repeat (4) @(negedge SYS_CLK);
    rd_chk(ADDR_DIAG_EN, RST_DIAG_EN);
    rd_chk(ADDR_LOOP_CTRL, RST_LOOP_CTRL);
    rd_chk(ADDR_IMP_CH1, RST_RESULT);
    rd_chk(ADDR_STATE_RPT, {4'h0, CH_FLOAT, CH_FLOAT});
    rd_chk(8'h40, 8'h00);
    $display("test reset values done");
    // Reference phase: loopback on, tone withheld first
    wr_reg(ADDR_LOOP_CTRL, 8'h80);
    tone = 0;
    wr_reg(ADDR_DIAG_EN, 8'h08);
    repeat (50) @(negedge SYS_CLK);
    chk({6'h0, DIAG_CH}, 8'h00);
    chk({5'h0, SDA_OUT, LOOP_EN, SENSE_LOOP_CH1}, 8'h03);
    tone = 1;
    wait_ch(2'b01);
    // Clock enable low holds the ramp at its first level
    ce = 0;
    repeat (30) @(negedge SYS_CLK);
    chk({2'h0, DIAG_CH, STIM_GAIN}, {2'h0, 2'b01, RAMP_ZERO});
    ce = 1;
    wait_ch(2'b00);
    chk({gmax, STIM_GAIN}, {RAMP_TOP, RAMP_ZERO});
    rd_chk(ADDR_STATE_RPT, 8'h10);
    rd_chk(ADDR_IMP_CH1, 8'h5a);
    rd_chk(ADDR_PHASE_HI, 8'h12);
    rd_chk(ADDR_PHASE_LO, 8'h34);
    rd_chk(ADDR_STIM_HI, 8'h00);
    $display("test reference phase done");
    // Load phase on both channels, slow sense answer
    wr_reg(ADDR_DIAG_EN, 8'h00);
    wr_reg(ADDR_LOOP_CTRL, 8'h00);
    dly = 8'd40;
    vals = 40'h33_0102_0304;
    wr_reg(ADDR_DIAG_EN, 8'h0c);
    wait_ch(2'b01);
    wait_ch(2'b10);
    vals = 40'h77_0506_0708;
    wait_ch(2'b00);
    rd_chk(ADDR_IMP_CH1, 8'h33);
    rd_chk(ADDR_IMP_CH2, 8'h77);
    rd_chk(ADDR_PHASE_HI, 8'h05);
    rd_chk(ADDR_PHASE_LO, 8'h06);
    rd_chk(ADDR_STIM_HI, 8'h07);
    rd_chk(ADDR_STIM_LO, 8'h08);
    rd_chk(ADDR_STATE_RPT, 8'h30);
    wr_reg(ADDR_IMP_CH1, 8'hff);
    rd_chk(ADDR_IMP_CH1, 8'h33);
    $display("test load phase done");
    // Paralleled pair: channel 2 enable is not acted on
    wr_reg(ADDR_DIAG_EN, 8'h00);
    wr_reg(ADDR_MODE_CFG, 8'h30);
    chk({7'h0, PAIR_PARALLEL}, 8'h01);
    wr_reg(ADDR_DIAG_EN, 8'h04);
    repeat (300) @(negedge SYS_CLK);
    chk({6'h0, DIAG_CH}, 8'h00);
    wr_reg(ADDR_MODE_CFG, 8'h00);
    chk({7'h0, PAIR_PARALLEL}, 8'h00);
    wait_ch(2'b10);
    $display("test paralleled pair done");
    tally_and_finish;
  end
endmodule // acd_ac_load_diag_sequencer_tb
`default_nettype wire
